// [hw/soc_clk_div.v]
/*
 * Clock output divider: bus clock divided by twice a 3-bit field.
 * Assumes a single clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/1ps

module soc_clk_div (
    input wire clk,
    input wire arst_n,
    input wire [2:0] div_sel,
    output reg clk_out_q,
    output reg clk_out_en_q
);

reg [2:0] cnt_q;

// ----------------------------------------
// Half-period counter and toggle
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        cnt_q <= 3'h0;
        clk_out_q <= 1'b0;
        clk_out_en_q <= 1'b0;
    end else if (div_sel == 3'h0) begin
        cnt_q <= 3'h0;
        clk_out_q <= 1'b0;
        clk_out_en_q <= 1'b0;
    end else begin
        clk_out_en_q <= 1'b1;
        if (cnt_q >= div_sel - 3'h1) begin
            cnt_q <= 3'h0;
            clk_out_q <= ~clk_out_q;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
end

endmodule // soc_clk_div

// [hw/soc_consts.vh]
/*
 * Constants of the system option block: register offsets, field
 * positions, reset values and watchdog counts.
 * Assumes inclusion by bare name from the design files under hw/.
 */
`ifndef SOC_CONSTS_VH
`define SOC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SOC_ADDR_W 3
`define SOC_OFF_OPT1 3'h0
`define SOC_OFF_OPT2 3'h1
`define SOC_OFF_IDH 3'h2
`define SOC_OFF_IDL 3'h3
`define SOC_OFF_RST_CAUSE 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SOC_OPT1_TMO_HI 7
`define SOC_OPT1_TMO_LO 6
`define SOC_OPT1_STOP 5
`define SOC_OPT1_SER2 4
`define SOC_OPT1_I2C1 3
`define SOC_OPT2_WCLK 7
`define SOC_OPT2_WWIN 6
`define SOC_OPT2_ADTS 4
`define SOC_OPT2_DIV_HI 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SOC_OPT1_RST 8'hE0
`define SOC_OPT2_RST 8'h00

// ----------------------------------------
// Service sequence bytes
// ----------------------------------------
`define SOC_SVC_KEY1 8'h55
`define SOC_SVC_KEY2 8'hAA

// ----------------------------------------
// Watchdog counts (log2 overflow, window opens)
// ----------------------------------------
`define SOC_WDG_CNT_W 18
`define SOC_LPO_LOG_1 5'd5
`define SOC_LPO_LOG_2 5'd8
`define SOC_LPO_LOG_3 5'd10
`define SOC_BUS_LOG_1 5'd13
`define SOC_BUS_LOG_2 5'd16
`define SOC_BUS_LOG_3 5'd18
`define SOC_WIN_1 18'd6144
`define SOC_WIN_2 18'd49152
`define SOC_WIN_3 18'd196608

`endif

// [hw/soc_system_option_config.v]
/*
 * System option and identification register bank: write-once first and
 * partly write-once second option register, watchdog, stop permit, pin routing, ADC trigger select,
 * clock output divider and part identification.
 * Assumes a plain register port synchronous to clk and a 1 kHz tick
 * pulse from the low-power oscillator, also synchronous to clk.
 */
`timescale 1ns/1ps
`include "soc_consts.vh"

//
// Contract
// - First option register takes only the first write after reset; always readable.
// - Timeout field with clock select sets period; zero disables; 1 kHz gives 2^5/2^8/2^10.
// - Clock select 0 is 1 kHz, 1 is bus; bus gives 2^13/2^16/2^18.
// - Windowed: any reset-status write in first three quarters resets chip.
// - Window opens after 6144, 49152 or 196608 bus counts.
// - Windowed only when window bit set and bus clock selected.
// - Stop permit 1 allows stop; 0 turns stop into illegal-opcode reset.
// - Bit 4 routes serial port 2 to port F 0/1 or port E 6/7.
// - Bit 3 routes I2C port 1 to port F 2/3 or port E 4/5.
// - Watchdog clock select and window enable accept one write after reset.
// - ADC trigger source bit selects counter overflow or interrupt pin.
// - Nonzero divider outputs bus clock over twice value on port A bit 0.
// - Hard-wired 12-bit part number split across two read-only registers.
// - High ID register holds revision in upper bits; writes ignored.
// - 0x55 then 0xAA restarts watchdog; other values force reset when enabled.
module soc_system_option_config #(
    parameter [11:0] PART_NUMBER = 12'h0_ABC, // Arbitrary value
    parameter [3:0] REVISION = 4'h1 // Arbitrary value
) (
    input wire clk,
    input wire arst_n,
    input wire [`SOC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    input wire lpo_tick,
    input wire stop_exec,
    input wire adc_hw_trigger_enable,
    input wire rtc_overflow,
    input wire irq_pin,
    input wire serial2_transmit,
    output reg serial2_receive_q,
    input wire i2c1_clock_out,
    input wire i2c1_clock_oe,
    output reg i2c1_clock_in_q,
    input wire i2c1_data_out,
    input wire i2c1_data_oe,
    output reg i2c1_data_in_q,
    input wire port_f_bit1_in,
    input wire port_f_bit2_in,
    input wire port_f_bit3_in,
    input wire port_e_bit4_in,
    input wire port_e_bit5_in,
    input wire port_e_bit7_in,
    output reg port_f_bit0_out_q,
    output reg port_f_bit0_oe_q,
    output reg port_f_bit2_out_q,
    output reg port_f_bit2_oe_q,
    output reg port_f_bit3_out_q,
    output reg port_f_bit3_oe_q,
    output reg port_e_bit4_out_q,
    output reg port_e_bit4_oe_q,
    output reg port_e_bit5_out_q,
    output reg port_e_bit5_oe_q,
    output reg port_e_bit6_out_q,
    output reg port_e_bit6_oe_q,
    output reg port_a_bit0_out_q,
    output reg port_a_bit0_oe_q,
    output reg adc_trigger_q,
    output reg stop_enter_q,
    output reg illegal_opcode_reset_q,
    output reg watchdog_reset_q
);

// ----------------------------------------
// Register state
// ----------------------------------------
reg [7:0] opt1_q;
reg opt1_locked_q;
reg wclk_q;
reg wclk_locked_q;
reg wwin_q;
reg wwin_locked_q;
reg adts_q;
reg [2:0] div_q;
reg [7:0] rdata_d;
wire wr_opt1;
wire wr_opt2;
wire wr_rst_cause;
wire wdg_reset;
wire div_clk;
wire div_en;
wire stop_permit;
wire serial2_pin_route;
wire i2c1_pin_route;
wire adc_trigger_source;

assign wr_opt1 = reg_wr && (reg_addr == `SOC_OFF_OPT1);
assign wr_opt2 = reg_wr && (reg_addr == `SOC_OFF_OPT2);
assign wr_rst_cause = reg_wr && (reg_addr == `SOC_OFF_RST_CAUSE);
assign stop_permit = opt1_q[`SOC_OPT1_STOP];
assign serial2_pin_route = opt1_q[`SOC_OPT1_SER2];
assign i2c1_pin_route = opt1_q[`SOC_OPT1_I2C1];
assign adc_trigger_source = adts_q;

// First option register, write-once
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        opt1_q <= `SOC_OPT1_RST;
        opt1_locked_q <= 1'b0;
    end else if (wr_opt1 && !opt1_locked_q) begin
        opt1_q <= reg_wdata;
        opt1_locked_q <= 1'b1;
    end
end

// Second option register: two write-once bits and two free bit groups
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        wclk_q <= 1'b0; // Low-power clock after reset
        wclk_locked_q <= 1'b0;
        wwin_q <= 1'b0;
        wwin_locked_q <= 1'b0;
        adts_q <= 1'b0;
        div_q <= 3'h0;
    end else if (wr_opt2) begin
        if (!wclk_locked_q) begin
            wclk_q <= reg_wdata[`SOC_OPT2_WCLK];
            wclk_locked_q <= 1'b1;
        end
        if (!wwin_locked_q) begin
            wwin_q <= reg_wdata[`SOC_OPT2_WWIN];
            wwin_locked_q <= 1'b1;
        end
        adts_q <= reg_wdata[`SOC_OPT2_ADTS];
        div_q <= reg_wdata[`SOC_OPT2_DIV_HI:0];
    end
end

// ----------------------------------------
// Read path
// ----------------------------------------
always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
        `SOC_OFF_OPT1: rdata_d = opt1_q;
        `SOC_OFF_OPT2: rdata_d = {wclk_q, wwin_q, 1'b0, adts_q, 1'b0, div_q};
        `SOC_OFF_IDH: rdata_d = {REVISION, PART_NUMBER[11:8]};
        `SOC_OFF_IDL: rdata_d = PART_NUMBER[7:0];
        default: rdata_d = 8'h00;
    endcase
end

// Read data register, valid only the cycle after the strobe
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata_q <= 8'h00;
    end else begin
        reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
    end
end

// ----------------------------------------
// Watchdog and clock output
// ----------------------------------------
soc_watchdog u_wdg (
    .clk(clk),
    .arst_n(arst_n),
    .timeout_sel(opt1_q[`SOC_OPT1_TMO_HI:`SOC_OPT1_TMO_LO]),
    .clk_sel(wclk_q),
    .win_en(wwin_q),
    .lpo_tick(lpo_tick),
    .svc_wr(wr_rst_cause),
    .svc_data(reg_wdata),
    .wdg_reset_q(wdg_reset)
);

soc_clk_div u_div (
    .clk(clk),
    .arst_n(arst_n),
    .div_sel(div_q),
    .clk_out_q(div_clk),
    .clk_out_en_q(div_en)
);

// ----------------------------------------
// Stop, trigger and reset outputs
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        stop_enter_q <= 1'b0;
        illegal_opcode_reset_q <= 1'b0;
        adc_trigger_q <= 1'b0;
        watchdog_reset_q <= 1'b0;
        port_a_bit0_out_q <= 1'b0;
        port_a_bit0_oe_q <= 1'b0;
    end else begin
        stop_enter_q <= stop_exec && stop_permit;
        illegal_opcode_reset_q <= stop_exec && !stop_permit;
        adc_trigger_q <= adc_hw_trigger_enable && (adc_trigger_source ? irq_pin : rtc_overflow);
        watchdog_reset_q <= wdg_reset;
        port_a_bit0_out_q <= div_clk;
        port_a_bit0_oe_q <= div_en;
    end
end

// ----------------------------------------
// Pin routing
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        port_f_bit0_out_q <= 1'b0;
        port_f_bit0_oe_q <= 1'b0;
        port_e_bit6_out_q <= 1'b0;
        port_e_bit6_oe_q <= 1'b0;
        serial2_receive_q <= 1'b1;
        port_f_bit2_out_q <= 1'b0;
        port_f_bit2_oe_q <= 1'b0;
        port_f_bit3_out_q <= 1'b0;
        port_f_bit3_oe_q <= 1'b0;
        port_e_bit4_out_q <= 1'b0;
        port_e_bit4_oe_q <= 1'b0;
        port_e_bit5_out_q <= 1'b0;
        port_e_bit5_oe_q <= 1'b0;
        i2c1_clock_in_q <= 1'b1;
        i2c1_data_in_q <= 1'b1;
    end else begin
        // Serial port 2 transmit on one pin, receive from its partner
        port_f_bit0_out_q <= serial2_transmit;
        port_f_bit0_oe_q <= !serial2_pin_route;
        port_e_bit6_out_q <= serial2_transmit;
        port_e_bit6_oe_q <= serial2_pin_route;
        serial2_receive_q <= serial2_pin_route ? port_e_bit7_in : port_f_bit1_in;
        // I2C port 1 open-drain lines
        port_f_bit2_out_q <= i2c1_clock_out;
        port_f_bit2_oe_q <= i2c1_clock_oe && !i2c1_pin_route;
        port_f_bit3_out_q <= i2c1_data_out;
        port_f_bit3_oe_q <= i2c1_data_oe && !i2c1_pin_route;
        port_e_bit4_out_q <= i2c1_clock_out;
        port_e_bit4_oe_q <= i2c1_clock_oe && i2c1_pin_route;
        port_e_bit5_out_q <= i2c1_data_out;
        port_e_bit5_oe_q <= i2c1_data_oe && i2c1_pin_route;
        i2c1_clock_in_q <= i2c1_pin_route ? port_e_bit4_in : port_f_bit2_in;
        i2c1_data_in_q <= i2c1_pin_route ? port_e_bit5_in : port_f_bit3_in;
    end
end

endmodule // soc_system_option_config

// [hw/soc_watchdog.v]
/*
 * Watchdog counter with normal and windowed modes.
 * Assumes lpo_tick is a one-cycle pulse per 1 kHz period, synchronous to clk.
 */
`timescale 1ns/1ps
`include "soc_consts.vh"

module soc_watchdog (
    input wire clk,
    input wire arst_n,
    input wire [1:0] timeout_sel,
    input wire clk_sel,
    input wire win_en,
    input wire lpo_tick,
    input wire svc_wr,
    input wire [7:0] svc_data,
    output reg wdg_reset_q
);

reg [`SOC_WDG_CNT_W-1:0] cnt_q;
reg key1_seen_q;
reg [4:0] log_len;
reg [`SOC_WDG_CNT_W-1:0] win_open;
wire enabled;
wire tick;
wire windowed;
wire at_limit;
wire early;

assign enabled = (timeout_sel != 2'b00);
assign tick = clk_sel ? 1'b1 : lpo_tick;
assign windowed = win_en & clk_sel;

// Period and window lookup
always @* begin
    log_len = 5'd0;
    win_open = {`SOC_WDG_CNT_W{1'b0}};
    case ({clk_sel, timeout_sel})
        3'b001: log_len = `SOC_LPO_LOG_1;
        3'b010: log_len = `SOC_LPO_LOG_2;
        3'b011: log_len = `SOC_LPO_LOG_3;
        3'b101: begin
            log_len = `SOC_BUS_LOG_1;
            win_open = `SOC_WIN_1;
        end
        3'b110: begin
            log_len = `SOC_BUS_LOG_2;
            win_open = `SOC_WIN_2;
        end
        3'b111: begin
            log_len = `SOC_BUS_LOG_3;
            win_open = `SOC_WIN_3;
        end
        default: log_len = 5'd0;
    endcase
end

assign at_limit = ({1'b0, cnt_q} >= (({{`SOC_WDG_CNT_W{1'b0}}, 1'b1} << log_len) - 1'b1));
assign early = windowed && (cnt_q < win_open);

// ----------------------------------------
// Counter, service sequence and reset request
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        cnt_q <= {`SOC_WDG_CNT_W{1'b0}};
        key1_seen_q <= 1'b0;
        wdg_reset_q <= 1'b0;
    end else begin
        wdg_reset_q <= 1'b0;
        if (!enabled) begin
            cnt_q <= {`SOC_WDG_CNT_W{1'b0}};
            key1_seen_q <= 1'b0;
        end else if (svc_wr) begin
            if (early) begin
                wdg_reset_q <= 1'b1;
                key1_seen_q <= 1'b0;
            end else if (svc_data == `SOC_SVC_KEY1) begin
                key1_seen_q <= 1'b1;
            end else if (svc_data == `SOC_SVC_KEY2 && key1_seen_q) begin
                cnt_q <= {`SOC_WDG_CNT_W{1'b0}};
                key1_seen_q <= 1'b0;
            end else begin
                wdg_reset_q <= 1'b1;
                key1_seen_q <= 1'b0;
            end
        end else if (tick) begin
            if (at_limit) begin
                wdg_reset_q <= 1'b1;
                cnt_q <= {`SOC_WDG_CNT_W{1'b0}};
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
end

endmodule // soc_watchdog

// [verification/soc_system_option_config_checker.sv]
/*
 * Port-level assertions for the system option block.
 * Assumes it is bound to soc_system_option_config and sees its ports only.
 */
`timescale 1ns/1ps

module soc_system_option_config_checker #(
    parameter [11:0] PART_NUMBER = 12'h000,
    parameter [3:0] REVISION = 4'h0
) (
    input wire clk,
    input wire arst_n,
    input wire [2:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire stop_exec,
    input wire stop_enter_q,
    input wire illegal_opcode_reset_q,
    input wire serial2_transmit,
    input wire port_f_bit0_out_q,
    input wire port_f_bit0_oe_q,
    input wire port_e_bit6_oe_q,
    input wire port_f_bit2_oe_q,
    input wire port_e_bit4_oe_q,
    input wire adc_hw_trigger_enable,
    input wire adc_trigger_q,
    input wire watchdog_reset_q
);
    // One clock domain, one reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data outside read slot");
    id_low_a: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata_q == PART_NUMBER[7:0])
        else $error("low id read wrong");
    id_high_a: assert property (reg_rd && reg_addr == 3'h2 |=> reg_rdata_q == {REVISION, PART_NUMBER[11:8]})
        else $error("high id read wrong");
    stop_choice_a: assert property (stop_exec |=> stop_enter_q != illegal_opcode_reset_q)
        else $error("stop gave no single outcome");
    stop_quiet_a: assert property (!stop_exec |=> !stop_enter_q && !illegal_opcode_reset_q)
        else $error("stop outcome without stop");
    ser_one_pad_a: assert property (!(port_f_bit0_oe_q && port_e_bit6_oe_q))
        else $error("serial transmit on two pads");
    ser_tx_follow_a: assert property (port_f_bit0_oe_q |-> port_f_bit0_out_q == $past(serial2_transmit))
        else $error("serial transmit pad lags");
    i2c_one_pad_a: assert property (!(port_f_bit2_oe_q && port_e_bit4_oe_q))
        else $error("i2c clock on two pads");
    adc_gate_a: assert property (!adc_hw_trigger_enable |=> !adc_trigger_q)
        else $error("adc trigger while disabled");
    wdg_single_a: assert property (watchdog_reset_q |=> !watchdog_reset_q)
        else $error("watchdog reset longer than a pulse");
endmodule // soc_system_option_config_checker

bind soc_system_option_config soc_system_option_config_checker #(
    .PART_NUMBER(PART_NUMBER),
    .REVISION(REVISION)
) u_chk (.*);

// [verification/tb_soc_system_option_config.sv]
/*
 * Self-checking bench for the system option block with a register model.
 * Assumes the design files under hw/ and the bound checker are compiled first.
 */
`timescale 1ns/1ps

module tb_soc_system_option_config;
    localparam [11:0] PN = 12'h5A3; // Arbitrary value
    localparam [3:0] RV = 4'h2; // Arbitrary value
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [2:0] reg_addr = 3'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0, reg_rd = 1'b0, lpo_tick = 1'b0, stop_exec = 1'b0;
    reg [13:0] rin = 14'h0000;
    reg [31:0] lf = 32'h8c80_558e;
    reg [7:0] o1, o2;
    reg l1, l2;
    integer samples_checked = 0, err_total = 0, wdg_n = 0, i, n, s;
    wire adc_hw_trigger_enable, rtc_overflow, irq_pin, serial2_transmit, i2c1_clock_out, i2c1_clock_oe;
    wire i2c1_data_out, i2c1_data_oe, port_f_bit1_in, port_f_bit2_in, port_f_bit3_in;
    wire port_e_bit4_in, port_e_bit5_in, port_e_bit7_in;
    wire [7:0] reg_rdata_q;
    wire serial2_receive_q, i2c1_clock_in_q, i2c1_data_in_q, port_f_bit0_out_q, port_f_bit0_oe_q;
    wire port_f_bit2_out_q, port_f_bit2_oe_q, port_f_bit3_out_q, port_f_bit3_oe_q, port_e_bit4_out_q;
    wire port_e_bit4_oe_q, port_e_bit5_out_q, port_e_bit5_oe_q, port_e_bit6_out_q, port_e_bit6_oe_q;
    wire port_a_bit0_out_q, port_a_bit0_oe_q, adc_trigger_q, stop_enter_q, illegal_opcode_reset_q;
    wire watchdog_reset_q;

    // Random pad and trigger inputs
    assign {port_e_bit7_in, port_e_bit5_in, port_e_bit4_in, port_f_bit3_in, port_f_bit2_in, port_f_bit1_in,
        i2c1_data_oe, i2c1_data_out, i2c1_clock_oe, i2c1_clock_out, serial2_transmit, irq_pin, rtc_overflow,
        adc_hw_trigger_enable} = rin;

    soc_system_option_config #(.PART_NUMBER(PN), .REVISION(RV)) dut (.*);

    // Clock and watchdog pulse counter
    always #2.5 clk = ~clk;
    always @(posedge clk) if (watchdog_reset_q === 1'b1) wdg_n <= wdg_n + 1;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Random source for the pad and trigger inputs
    function [31:0] lfsr_next(input [31:0] v);
        begin
            lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        end
    endfunction

    task conclude;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask

    task rst;
        begin
            @(posedge clk);
            arst_n <= 1'b0;
            repeat (12) @(posedge clk);
            arst_n <= 1'b1;
            o1 = 8'hE0;
            o2 = 8'h00;
            l1 = 1'b0;
            l2 = 1'b0;
        end
    endtask

    // Write cycle, model keeps the write-once locks
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
            if (a == 3'h0 && !l1) begin
                o1 = d;
                l1 = 1'b1;
            end
            if (a == 3'h1) begin
                o2 = l2 ? {o2[7:6], d[5:0]} : d;
                l2 = 1'b1;
            end
        end
    endtask

    task rd(input [2:0] a, input [7:0] m, input [7:0] e);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            chk(reg_rdata_q & m, e & m);
        end
    endtask

    task regs;
        begin
            rd(3'h0, 8'hF8, o1);
            rd(3'h1, 8'hD7, o2);
            rd(3'h2, 8'hFF, {RV, PN[11:8]});
            rd(3'h3, 8'hFF, PN[7:0]);
            rd(3'h7, 8'hFF, 8'h00);
        end
    endtask

    task wdg_wr(input [7:0] d, input e);
        begin
            wr(3'h4, d);
            @(posedge clk);
            #1;
            chk(watchdog_reset_q, e);
        end
    endtask

    task stopchk(input [1:0] e);
        begin
            @(posedge clk);
            stop_exec <= 1'b1;
            @(posedge clk);
            stop_exec <= 1'b0;
            #1;
            chk({stop_enter_q, illegal_opcode_reset_q}, e);
        end
    endtask

    // Random traffic through the routed pads and the trigger mux
    task rnd;
        reg [13:0] p;
        reg sr, ir;
        begin
            sr = o1[4];
            ir = o1[3];
            repeat (16) begin
                @(posedge clk);
                lf = lfsr_next(lf);
                p = lf[13:0];
                rin <= p;
                @(posedge clk);
                #1;
                chk(adc_trigger_q, p[0] & (o2[4] ? p[2] : p[1]));
                chk(sr ? {port_e_bit6_out_q, port_e_bit6_oe_q, port_f_bit0_oe_q, serial2_receive_q}
                    : {port_f_bit0_out_q, port_f_bit0_oe_q, port_e_bit6_oe_q, serial2_receive_q},
                    {p[3], 2'b10, sr ? p[13] : p[8]});
                chk(ir ? {port_e_bit4_out_q & port_e_bit4_oe_q, port_e_bit4_oe_q, port_e_bit5_out_q & port_e_bit5_oe_q,
                    port_e_bit5_oe_q, port_f_bit2_oe_q, port_f_bit3_oe_q, i2c1_clock_in_q, i2c1_data_in_q}
                    : {port_f_bit2_out_q & port_f_bit2_oe_q, port_f_bit2_oe_q, port_f_bit3_out_q & port_f_bit3_oe_q,
                    port_f_bit3_oe_q, port_e_bit4_oe_q, port_e_bit5_oe_q, i2c1_clock_in_q, i2c1_data_in_q},
                    {p[4] & p[5], p[5], p[6] & p[7], p[7], 2'b00, ir ? p[11] : p[9], ir ? p[12] : p[10]});
            end
        end
    endtask

    // Half period of the divided clock, 40 means no toggle
    task divchk(input [2:0] d);
        reg v;
        integer k;
        begin
            wr(3'h1, {o2[7:3], d});
            repeat (3) @(posedge clk);
            for (k = 0; k < 2; k = k + 1) begin
                #1;
                v = port_a_bit0_out_q;
                n = 0;
                while (port_a_bit0_out_q === v && n < 40) begin
                    @(posedge clk);
                    #1;
                    n = n + 1;
                end
            end
            chk(n, d == 3'h0 ? 40 : d);
            chk(port_a_bit0_oe_q, d != 3'h0);
        end
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst;
        regs;
        wr(3'h2, 8'hFF);
        wr(3'h0, 8'h58);
        wr(3'h1, 8'h93);
        wdg_wr(8'h55, 1'b0);
        wdg_wr(8'hAA, 1'b0);
        s = wdg_n;
        n = 0;
        while (wdg_n == s && n < 9000) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        chk(n >= 8189 && n <= 8195, 1);
        wdg_wr(8'h12, 1'b1);
        wdg_wr(8'hAA, 1'b1);
        wr(3'h0, 8'hE0);
        wr(3'h1, 8'h45);
        regs;
        stopchk(2'b01);
        rnd;
        for (i = 0; i < 8; i = i + 1) divchk(i[2:0]);
        $display("test options and bus watchdog done");
        rst;
        wr(3'h0, 8'h20);
        wr(3'h1, 8'hC0);
        wr(3'h1, 8'h10);
        wdg_wr(8'h12, 1'b0);
        stopchk(2'b10);
        rnd;
        regs;
        $display("test alternate routing done");
        rst;
        wr(3'h0, 8'h40);
        wr(3'h1, 8'hC0);
        repeat (6300) @(posedge clk);
        wdg_wr(8'h55, 1'b0);
        wdg_wr(8'hAA, 1'b0);
        wdg_wr(8'h55, 1'b1);
        $display("test windowed watchdog done");
        // Every timeout length on the slow clock, window bit ignored there
        for (i = 1; i < 4; i = i + 1) begin
            rst;
            wr(3'h0, {i[1:0], 6'h00});
            wr(3'h1, 8'h40);
            wdg_wr(8'h55, 1'b0);
            wdg_wr(8'hAA, 1'b0);
            s = wdg_n;
            n = 0;
            while (wdg_n == s && n < 1100) begin
                @(posedge clk);
                lpo_tick <= 1'b1;
                @(posedge clk);
                lpo_tick <= 1'b0;
                n = n + 1;
                repeat (2) @(posedge clk);
                #1;
            end
            chk(n, i == 1 ? 32 : (i == 2 ? 256 : 1024));
        end
        $display("test slow clock watchdog done");
        conclude;
    end

    // Hang guard
    initial begin
        #400000;
        err_total = err_total + 1;
        conclude;
    end
endmodule // tb_soc_system_option_config
